/* addr_unit.sv */
// Address-register set/copy execution unit with attribute-based access width,
// loop nesting counter and replicated 16-bit register window read.
// Assumes all inputs come from logic on ref_clk, already decoded into fields.
`default_nettype none

// How it works
// - A set-address operation loads the chosen register with the 21-bit immediate and its attribute.
// - Either address operation may target any of the seven address-capable registers.
// - A copy-address operation writes source plus scaled displacement and the given attribute.
// - The 18-bit displacement is signed and is sign-extended before scaling and adding.
// - Long shifts the displacement left by two, short by one, unsigned char not at all.
// - Int shifts by two or by one according to the configured integer width.
// - The copy source is one of the seven registers or the work-address input.
// - The attribute is one of four codes: long, int, short or unsigned char.
// - No exception is raised for address errors, hazards, overflow or loop nesting depth.
// - A reserved encoding raises a one-cycle reserved-instruction exception.
// - Four nested loops are accepted when the innermost one is an on-fetch loop.
// - A 32-bit window read returns the 16-bit value in both halves.
// - The data access width follows the attribute of the register used for the access.
module addr_unit #(
   parameter int  ADDR_W   = addr_unit_pkg::ADDR_W,
   parameter int  DISP_W   = addr_unit_pkg::DISP_W,
   parameter bit  INT_LONG = 1'b1
)(
   // Clock, reset, enable
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   ce,
   // Decoded address-operation instruction
   input  wire logic                                   instr_valid,
   input  wire addr_unit_pkg::op_type                  instr_op,
   input  wire logic [addr_unit_pkg::SEL_W-1:0]        instr_dst,
   input  wire logic [addr_unit_pkg::SEL_W-1:0]        instr_src,
   input  wire addr_unit_pkg::attr_type                instr_attr,
   input  wire logic [ADDR_W-1:0]                      immediate_byte_address,
   input  wire logic [DISP_W-1:0]                      instr_disp,
   input  wire logic [ADDR_W-1:0]                      work_address_source,
   // Register read-back
   input  wire logic [addr_unit_pkg::SEL_W-1:0]        rd_sel,
   output logic      [ADDR_W-1:0]                      rd_addr,
   output addr_unit_pkg::attr_type                     rd_attr,
   // Memory operand access width
   input  wire logic [addr_unit_pkg::SEL_W-1:0]        acc_sel,
   output logic      [addr_unit_pkg::WIDTH_W-1:0]      acc_width,
   // Completion and exception
   output logic                                        op_done,
   output logic                                        reserved_exc,
   // Loop nesting
   input  wire logic                                   loop_push,
   input  wire logic                                   loop_on_fetch,
   input  wire logic                                   loop_pop,
   output logic      [addr_unit_pkg::LOOP_CNT_W-1:0]   loop_depth,
   output logic                                        loop_refused,
   // Register window read
   input  wire logic                                   io_rd_en,
   input  wire logic [addr_unit_pkg::IO_HALF_W-1:0]    io_half_data,
   output logic      [2*addr_unit_pkg::IO_HALF_W-1:0]  io_rd_data,
   output logic                                        io_rd_valid
);

   // ==========================================================================
   // Helper functions

   // Bytes moved per access for a given attribute.
   function automatic logic [addr_unit_pkg::WIDTH_W-1:0] attr_bytes
   (
      input addr_unit_pkg::attr_type attr
   );
      logic [addr_unit_pkg::WIDTH_W-1:0] bytes;
      bytes = addr_unit_pkg::WIDTH_CHAR_BYTES;
      case (attr)
         addr_unit_pkg::ATTR_LONG:  bytes = addr_unit_pkg::WIDTH_LONG_BYTES;
         addr_unit_pkg::ATTR_INT:   bytes = INT_LONG ? addr_unit_pkg::WIDTH_LONG_BYTES
                                                     : addr_unit_pkg::WIDTH_SHRT_BYTES;
         addr_unit_pkg::ATTR_SHORT: bytes = addr_unit_pkg::WIDTH_SHRT_BYTES;
         addr_unit_pkg::ATTR_UCHAR: bytes = addr_unit_pkg::WIDTH_CHAR_BYTES;
         default:                   bytes = addr_unit_pkg::WIDTH_CHAR_BYTES;
      endcase
      return bytes;
   endfunction

   // Left-shift amount that turns an element count into a byte offset.
   function automatic logic [1:0] attr_shift
   (
      input addr_unit_pkg::attr_type attr
   );
      logic [1:0] sh;
      sh = 2'h0;
      case (attr)
         addr_unit_pkg::ATTR_LONG:  sh = 2'h2;
         addr_unit_pkg::ATTR_INT:   sh = INT_LONG ? 2'h2 : 2'h1;
         addr_unit_pkg::ATTR_SHORT: sh = 2'h1;
         addr_unit_pkg::ATTR_UCHAR: sh = 2'h0;
         default:                   sh = 2'h0;
      endcase
      return sh;
   endfunction

   // True for the seven register codes, false for the work-address code.
   function automatic logic names_areg
   (
      input logic [addr_unit_pkg::SEL_W-1:0] sel
   );
      return (sel != addr_unit_pkg::REG_WORK);
   endfunction

   // ==========================================================================
   // Register file storage
   logic                     [ADDR_W-1:0] addr_reg [addr_unit_pkg::NUM_AREGS];
   addr_unit_pkg::attr_type               attr_reg [addr_unit_pkg::NUM_AREGS];

   // ==========================================================================
   // Decode
   wire logic is_set;
   wire logic is_copy;
   wire logic dst_ok;
   wire logic op_reserved;
   wire logic wants_write;
   wire logic is_reserved;
   wire logic do_write;

   // The work-address code only names a source, so as a destination it is
   // an illegal encoding rather than a silent no-op.
   assign dst_ok      = names_areg(instr_dst);
   assign is_set      = instr_valid && (instr_op == addr_unit_pkg::OP_SET);
   assign is_copy     = instr_valid && (instr_op == addr_unit_pkg::OP_COPY);
   assign op_reserved = instr_valid && (instr_op == addr_unit_pkg::OP_RESERVED);
   assign wants_write = is_set || is_copy;
   assign is_reserved = op_reserved || (wants_write && !dst_ok);
   assign do_write    = wants_write && dst_ok;

   // ==========================================================================
   // Source selection and displacement arithmetic
   wire logic [ADDR_W-1:0] src_value;
   wire logic [ADDR_W+1:0] disp_ext;
   wire logic [ADDR_W+1:0] disp_scaled;
   wire logic [ADDR_W-1:0] copy_value;
   wire logic [ADDR_W-1:0] next_value;
   wire logic [1:0]        shift_amt;
   wire logic [ADDR_W-1:0] scaled_low;

   assign src_value   = (instr_src == addr_unit_pkg::REG_WORK)
                        ? work_address_source
                        : addr_reg[instr_src];
   assign disp_ext    = {{(ADDR_W+2-DISP_W){instr_disp[DISP_W-1]}}, instr_disp};
   assign shift_amt   = attr_shift(instr_attr);
   assign disp_scaled = disp_ext << shift_amt;
   // Wrap-around past the address space is deliberate: nothing traps it.
   assign scaled_low  = disp_scaled[ADDR_W-1:0];
   assign copy_value  = src_value + scaled_low;
   assign next_value  = is_set ? immediate_byte_address : copy_value;

   // ==========================================================================
   // Register file update
   // Reset waits for the enable as well, so a frozen unit keeps every bit.
   genvar g;
   generate
      for (g = 0; g < addr_unit_pkg::NUM_AREGS; g++)
      begin : g_areg
         wire logic hit;
         assign hit = do_write && (instr_dst == addr_unit_pkg::SEL_W'(g));

         always_ff @(posedge ref_clk)
         begin
            if (ce)
            begin
               if (!rst_n)
               begin
                  addr_reg[g] <= addr_unit_pkg::ADDR_RESET;
                  attr_reg[g] <= addr_unit_pkg::ATTR_RESET;
               end
               else if (hit)
               begin
                  addr_reg[g] <= next_value;
                  attr_reg[g] <= instr_attr;
               end
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Read-back and access width
   wire logic                                  rd_is_reg;
   wire logic                                  acc_is_reg;
   wire logic                     [ADDR_W-1:0] next_rd_addr;
   wire addr_unit_pkg::attr_type               next_rd_attr;
   wire logic [addr_unit_pkg::WIDTH_W-1:0]     next_acc_width;

   assign rd_is_reg      = names_areg(rd_sel);
   assign acc_is_reg     = names_areg(acc_sel);
   assign next_rd_addr   = rd_is_reg ? addr_reg[rd_sel] : work_address_source;
   assign next_rd_attr   = rd_is_reg ? attr_reg[rd_sel] : addr_unit_pkg::ATTR_RESET;
   assign next_acc_width = acc_is_reg ? attr_bytes(attr_reg[acc_sel])
                                      : addr_unit_pkg::WIDTH_CHAR_BYTES;

   always_ff @(posedge ref_clk)
   begin
      if (ce)
      begin
         if (!rst_n)
         begin
            rd_addr   <= addr_unit_pkg::ADDR_RESET;
            rd_attr   <= addr_unit_pkg::ATTR_RESET;
            acc_width <= addr_unit_pkg::WIDTH_CHAR_BYTES;
         end
         else
         begin
            rd_addr   <= next_rd_addr;
            rd_attr   <= next_rd_attr;
            acc_width <= next_acc_width;
         end
      end
   end

   // ==========================================================================
   // Completion and exception flags
   always_ff @(posedge ref_clk)
   begin
      if (ce)
      begin
         if (!rst_n)
         begin
            op_done      <= 1'b0;
            reserved_exc <= 1'b0;
         end
         else
         begin
            op_done      <= do_write;
            reserved_exc <= is_reserved;
         end
      end
   end

   // ==========================================================================
   // Loop nesting
   // The limit depends only on the loop being opened: a fourth level is
   // only possible when that innermost loop runs on fetch. An over-deep
   // push is refused quietly, since the hardware raises no nesting error.
   wire logic                                 push_alone;
   wire logic                                 push_ok;
   wire logic                                 pop_ok;
   wire logic [addr_unit_pkg::LOOP_CNT_W-1:0] depth_limit;
   wire logic [addr_unit_pkg::LOOP_CNT_W-1:0] next_depth;

   assign depth_limit = loop_on_fetch
                        ? addr_unit_pkg::LOOP_CNT_W'(addr_unit_pkg::LOOP_DEPTH_FETCH)
                        : addr_unit_pkg::LOOP_CNT_W'(addr_unit_pkg::LOOP_DEPTH_OTHER);
   assign push_alone  = loop_push && !loop_pop;
   assign push_ok     = push_alone && (loop_depth < depth_limit);
   assign pop_ok      = loop_pop && !loop_push && (loop_depth != addr_unit_pkg::LOOP_RESET);
   assign next_depth  = push_ok ? loop_depth + 3'h1
                      : pop_ok  ? loop_depth - 3'h1
                      : loop_depth;

   always_ff @(posedge ref_clk)
   begin
      if (ce)
      begin
         if (!rst_n)
         begin
            loop_depth   <= addr_unit_pkg::LOOP_RESET;
            loop_refused <= 1'b0;
         end
         else
         begin
            loop_depth   <= next_depth;
            loop_refused <= push_alone && !push_ok;
         end
      end
   end

   // ==========================================================================
   // Register window read
   // The window is only 16 bits wide, so a word read sees the same half twice.
   wire logic [2*addr_unit_pkg::IO_HALF_W-1:0] next_io_data;

   assign next_io_data = {io_half_data, io_half_data};

   always_ff @(posedge ref_clk)
   begin
      if (ce)
      begin
         if (!rst_n)
         begin
            io_rd_data  <= 32'h00000000;
            io_rd_valid <= 1'b0;
         end
         else
         begin
            io_rd_valid <= io_rd_en;
            if (io_rd_en)
            begin
               io_rd_data <= next_io_data;
            end
         end
      end
   end

endmodule // addr_unit

`default_nettype wire

/* addr_unit_pkg.sv */
// Shared constants and types for the address-register execution unit.
// Assumes one core clock and a decoder that hands over pre-split instruction fields.
`default_nettype none

package addr_unit_pkg;

   // ==========================================================================
   // Widths and counts
   localparam int ADDR_W           = 21;
   localparam int DISP_W           = 18;
   localparam int NUM_AREGS        = 7;
   localparam int SEL_W            = 3;
   localparam int IO_HALF_W        = 16;
   localparam int LOOP_CNT_W       = 3;
   localparam int WIDTH_W          = 3;
   localparam int LOOP_DEPTH_FETCH = 4;
   localparam int LOOP_DEPTH_OTHER = 3;

   // ==========================================================================
   // Address attributes
   typedef enum logic [1:0]
   {
      ATTR_LONG  = 2'h0,
      ATTR_INT   = 2'h1,
      ATTR_SHORT = 2'h2,
      ATTR_UCHAR = 2'h3
   } attr_type;

   // ==========================================================================
   // Address-operation kinds coming from the decoder
   typedef enum logic [1:0]
   {
      OP_NONE     = 2'h0,
      OP_SET      = 2'h1,
      OP_COPY     = 2'h2,
      OP_RESERVED = 2'h3
   } op_type;

   // ==========================================================================
   // Register selector codes; the work-address code is a source only
   typedef enum logic [2:0]
   {
      REG_GP0    = 3'h0,
      REG_GP1    = 3'h1,
      REG_GP2    = 3'h2,
      REG_DEST   = 3'h3,
      REG_XSRC   = 3'h4,
      REG_YSRC   = 3'h5,
      REG_SHARED = 3'h6,
      REG_WORK   = 3'h7
   } areg_type;

   // ==========================================================================
   // Values after reset and access widths in bytes
   localparam logic [ADDR_W-1:0]     ADDR_RESET       = 21'h000000;
   localparam attr_type              ATTR_RESET       = ATTR_UCHAR;
   localparam logic [LOOP_CNT_W-1:0] LOOP_RESET       = 3'h0;
   localparam logic [WIDTH_W-1:0]    WIDTH_LONG_BYTES = 3'h4;
   localparam logic [WIDTH_W-1:0]    WIDTH_SHRT_BYTES = 3'h2;
   localparam logic [WIDTH_W-1:0]    WIDTH_CHAR_BYTES = 3'h1;

endpackage

`default_nettype wire

/* window_source.sv */
// Host-side source of the register window half value.
// Assumes the bench loads half_value in the same cycle as it raises io_rd_en.
`default_nettype none
module window_source (
   // Window read
   input  wire logic        io_rd_en,
   input  wire logic [15:0] half_value,
   output logic      [15:0] io_half_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Off a read the half is inverted, so a stale value never passes as fresh.
   assign io_half_data = io_rd_en ? half_value : ~half_value;
endmodule // window_source
`default_nettype wire

/* addr_unit_properties.sv */
// Port checks for addr_unit, bound into every instance of it.
// Assumes one clock, a synchronous active-low reset and codes in package order.
`default_nettype none
module addr_unit_properties #(
   parameter int ADDR_W   = addr_unit_pkg::ADDR_W,
   parameter int DISP_W   = addr_unit_pkg::DISP_W,
   parameter bit INT_LONG = 1'b1
)(
   // Inputs of the unit
   input wire logic              ref_clk, rst_n, ce, instr_valid, io_rd_en,
   input wire logic              loop_push, loop_on_fetch, loop_pop,
   input wire addr_unit_pkg::op_type   instr_op,
   input wire addr_unit_pkg::attr_type instr_attr,
   input wire logic [2:0]        instr_dst, instr_src, rd_sel, acc_sel,
   input wire logic [ADDR_W-1:0] immediate_byte_address, work_address_source,
   input wire logic [DISP_W-1:0] instr_disp,
   input wire logic [15:0]       io_half_data,
   // Outputs of the unit
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire addr_unit_pkg::attr_type rd_attr,
   input wire logic [2:0]        acc_width, loop_depth,
   input wire logic              op_done, reserved_exc, loop_refused, io_rd_valid,
   input wire logic [31:0]       io_rd_data
);
   // ====================
   // Last accepted write
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Register sources are judged by the bench; only the work source is visible here.
   wire              legal = ce && instr_valid && instr_dst != 3'h7;
   wire [1:0]        sh = (instr_attr == 2'h0 || (instr_attr == 2'h1 && INT_LONG)) ? 2'h2
                          : {1'b0, instr_attr != 2'h3};
   wire [ADDR_W-1:0] ext = ADDR_W'(signed'(instr_disp));
   logic             wr_q, cp_q;
   logic [2:0]       dst_q;
   logic [1:0]       at_q;
   logic [ADDR_W-1:0] val_q;
   wire [2:0]        wid = (at_q == 2'h0 || (at_q == 2'h1 && INT_LONG)) ? 3'h4
                           : (at_q == 2'h3 ? 3'h1 : 3'h2);
   always_ff @(posedge ref_clk)
   begin
      wr_q  <= rst_n && legal && instr_op == 2'h1;
      cp_q  <= rst_n && legal && instr_op == 2'h2 && instr_src == 3'h7;
      dst_q <= instr_dst;
      at_q  <= instr_attr;
      val_q <= instr_op == 2'h1 ? immediate_byte_address : work_address_source + (ext << sh);
   end
   // ====================
   // Port relations
   a_write_done:
      assert property (legal && instr_op inside {2'h1, 2'h2} |=> op_done && !reserved_exc)
      else $error("Write gave no completion pulse.");
   a_refuse_reserved:
      assert property (ce && instr_valid && (instr_op == 2'h3 || (instr_op != 2'h0
         && instr_dst == 3'h7)) |=> reserved_exc && !op_done)
      else $error("Refused code gave no exception.");
   a_quiet_idle:
      assert property (ce && !instr_valid |=> !reserved_exc && !op_done)
      else $error("Pulse without an instruction.");
   a_set_value:
      assert property (ce && wr_q && rd_sel == dst_q |=> rd_addr == $past(val_q))
      else $error("Set value not held.");
   a_copy_sum:
      assert property (ce && cp_q && rd_sel == dst_q |=> rd_addr == $past(val_q))
      else $error("Copy sum wrong.");
   a_attr_kept:
      assert property (ce && (wr_q || cp_q) && rd_sel == dst_q |=> rd_attr == $past(at_q))
      else $error("Attribute not updated with address.");
   a_access_width:
      assert property (ce && (wr_q || cp_q) && acc_sel == dst_q |=> acc_width == $past(wid))
      else $error("Access width wrong.");
   a_loop_limit:
      assert property (ce && loop_push && !loop_pop && loop_depth == 3'h3
         |=> $past(loop_on_fetch) ? (loop_depth == 3'h4 && !loop_refused)
         : (loop_depth == 3'h3 && loop_refused))
      else $error("Loop limit wrong.");
   a_window_copy:
      assert property (ce && io_rd_en |=> io_rd_valid && io_rd_data == {2{$past(io_half_data)}})
      else $error("Window halves differ.");
   c_set: cover property (ce && wr_q);
   c_copy: cover property (ce && cp_q);
   c_refused: cover property (loop_refused);
endmodule // addr_unit_properties
bind addr_unit addr_unit_properties #(.ADDR_W(ADDR_W), .DISP_W(DISP_W), .INT_LONG(INT_LONG))
   u_props (.ref_clk, .rst_n, .ce, .instr_valid, .io_rd_en, .loop_push, .loop_on_fetch,
      .loop_pop, .instr_op, .instr_attr, .instr_dst, .instr_src, .rd_sel, .acc_sel,
      .immediate_byte_address, .work_address_source, .instr_disp, .io_half_data, .rd_addr,
      .rd_attr, .acc_width, .loop_depth, .op_done, .reserved_exc, .loop_refused,
      .io_rd_valid, .io_rd_data);
`default_nettype wire

/* address_register_set_copy_unit_test.sv */
// Self-checking bench for addr_unit: reset state, set, copy, refusals, loops, window.
// Assumes the checker binds itself into addr_unit.
`default_nettype none
module address_register_set_copy_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Signals and reference model
   logic        ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, instr_valid = 1'b0;
   logic        loop_push = 1'b0, loop_on_fetch = 1'b0, loop_pop = 1'b0, io_rd_en = 1'b0;
   addr_unit_pkg::op_type   instr_op = addr_unit_pkg::OP_NONE;
   addr_unit_pkg::attr_type instr_attr = addr_unit_pkg::ATTR_LONG, rd_attr, et [8];
   logic [2:0]  instr_dst = 3'h0, instr_src = 3'h0, rd_sel = 3'h0, acc_sel = 3'h0;
   logic [20:0] immediate_byte_address = 21'h000000, work_address_source = 21'h1F0F0A;
   logic [17:0] instr_disp = 18'h00000;
   logic [15:0] half_value = 16'h0000, io_half_data;
   logic [20:0] rd_addr, ea [8];
   logic [2:0]  acc_width, loop_depth;
   logic        op_done, reserved_exc, loop_refused, io_rd_valid;
   logic [31:0] io_rd_data;
   int          num_errors = 0, total_checks = 0;
   addr_unit #(.INT_LONG(1'b1)) u_dut (.ref_clk, .rst_n, .ce, .instr_valid, .instr_op,
      .instr_dst, .instr_src, .instr_attr, .immediate_byte_address, .instr_disp,
      .work_address_source, .rd_sel, .rd_addr, .rd_attr, .acc_sel, .acc_width, .op_done,
      .reserved_exc, .loop_push, .loop_on_fetch, .loop_pop, .loop_depth, .loop_refused,
      .io_rd_en, .io_half_data, .io_rd_data, .io_rd_valid);
   window_source u_src (.io_rd_en, .half_value, .io_half_data);
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end
   // ====================
   // Shared tasks
   task automatic check_val(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic read_reg(input int r);
      @(posedge ref_clk);
      rd_sel <= 3'(r);
      acc_sel <= 3'(r);
      @(posedge ref_clk);
      #1;
      check_val(32'(rd_addr), 32'(ea[r]));
      check_val(32'(rd_attr), 32'(et[r]));
      check_val(32'(acc_width), et[r] == 2'h3 ? 1 : (et[r] == 2'h2 ? 2 : 4));
   endtask
   // Integer attribute scales as long here, since the unit is built with INT_LONG set.
   task automatic issue(input logic [1:0] op, input int d, s, input logic [1:0] a,
                        input logic [20:0] imm, input logic [17:0] disp);
      logic        bad;
      logic [20:0] v;
      bad = op == 2'h3 || d == 7;
      v = (s == 7 ? work_address_source : ea[s % 7])
          + (21'(signed'(disp)) << (a == 2'h3 ? 0 : (a == 2'h2 ? 1 : 2)));
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr_op <= addr_unit_pkg::op_type'(op);
      instr_dst <= 3'(d);
      instr_src <= 3'(s);
      instr_attr <= addr_unit_pkg::attr_type'(a);
      immediate_byte_address <= imm;
      instr_disp <= disp;
      rd_sel <= 3'(d);
      acc_sel <= 3'(d);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      check_val(32'(op_done), 32'(!bad));
      check_val(32'(reserved_exc), 32'(bad));
      if (!bad)
      begin
         ea[d] = op == 2'h1 ? imm : v;
         et[d] = addr_unit_pkg::attr_type'(a);
         read_reg(d);
      end
   endtask
   task automatic loop_step(input logic pu, fe, po, input int dep, rf);
      @(posedge ref_clk);
      loop_push <= pu;
      loop_on_fetch <= fe;
      loop_pop <= po;
      @(posedge ref_clk);
      loop_push <= 1'b0;
      loop_pop <= 1'b0;
      #1;
      check_val(32'(loop_depth), dep);
      check_val(32'(loop_refused), rf);
      check_val(32'(reserved_exc), 0);
   endtask
   // ====================
   // Scenarios
   // Code 7 reads back the work-address input with the byte attribute.
   task automatic check_all();
      for (int r = 0; r < 8; r++)
         read_reg(r);
      check_val(32'(loop_depth), 0);
   endtask
   task automatic test_set();
      for (int r = 0; r < 7; r++)
         issue(2'h1, r, 0, 2'(r), 21'h1FFFFF - 21'(r), 18'h0);
   endtask
   task automatic test_copy();
      logic [17:0] dt [3] = '{18'h20000, 18'h1FFFF, 18'h3FFFD};
      for (int s = 0; s < 8; s++)
         for (int a = 0; a < 4; a++)
            issue(2'h2, (s + a) % 7, s, 2'(a), 21'h0, dt[(s + a) % 3]);
   endtask
   task automatic test_refused();
      issue(2'h3, 0, 1, 2'h0, 21'h0ABCDE, 18'h0);
      issue(2'h1, 7, 0, 2'h0, 21'h0ABCDE, 18'h0);
      issue(2'h2, 7, 1, 2'h1, 21'h0, 18'h4);
      check_all();
   endtask
   task automatic test_loop();
      for (int i = 1; i < 4; i++)
         loop_step(1'b1, 1'b0, 1'b0, i, 0);
      loop_step(1'b1, 1'b0, 1'b0, 3, 1);
      loop_step(1'b1, 1'b1, 1'b0, 4, 0);
      loop_step(1'b1, 1'b1, 1'b0, 4, 1);
      loop_step(1'b1, 1'b1, 1'b1, 4, 0);
      for (int i = 3; i >= 0; i--)
         loop_step(1'b0, 1'b0, 1'b1, i, 0);
      loop_step(1'b0, 1'b0, 1'b1, 0, 0);
   endtask
   // With the enable low, an instruction and a loop push must leave no trace.
   task automatic test_freeze();
      @(posedge ref_clk);
      ce <= 1'b0;
      instr_valid <= 1'b1;
      instr_op <= addr_unit_pkg::OP_SET;
      instr_dst <= 3'h0;
      immediate_byte_address <= 21'h0ABCDE;
      loop_push <= 1'b1;
      @(posedge ref_clk);
      ce <= 1'b1;
      instr_valid <= 1'b0;
      loop_push <= 1'b0;
      #1;
      check_val(32'(op_done), 0);
      check_val(32'(loop_depth), 0);
      read_reg(0);
   endtask
   task automatic test_window();
      @(posedge ref_clk);
      io_rd_en <= 1'b1;
      half_value <= 16'hA55A;
      @(posedge ref_clk);
      half_value <= 16'h81C3;
      #1;
      check_val(io_rd_data, 32'hA55AA55A);
      @(posedge ref_clk);
      io_rd_en <= 1'b0;
      #1;
      check_val(io_rd_data, 32'h81C381C3);
      @(posedge ref_clk);
      #1;
      check_val({io_rd_data[31:1], io_rd_valid}, 32'h81C381C2);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      for (int r = 0; r < 7; r++)
      begin
         ea[r] = 21'h000000;
         et[r] = addr_unit_pkg::ATTR_UCHAR;
      end
      ea[7] = work_address_source;
      et[7] = addr_unit_pkg::ATTR_UCHAR;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      check_all();
      test_set();
      test_copy();
      test_refused();
      test_loop();
      test_freeze();
      test_window();
      stop_test();
   end
endmodule // address_register_set_copy_unit_test
`default_nettype wire
